/* File: src/usa_alias.sv */
// UART shadow receive/transmit alias block with AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Function
// R1 - Sixteen word aliases reach one data path
// R2 - Read returns received byte, upper bits zero
// R3 - Read data valid only while data ready
// R4 - FIFOs off: new byte overwrites, flags overrun
// R5 - FIFOs on: read returns receive FIFO head
// R6 - Full receive FIFO drops new byte, overrun
// R7 - Written byte queued for serial or infrared
// R8 - Master writes only while holding empty set
// R9 - FIFOs off: one write clears holding empty
// R10 - FIFOs off: further writes overwrite pending byte
// R11 - FIFOs on: accept up to depth writes
// R12 - Write into full transmit FIFO is dropped
// R13 - Every alias identical; read pops once
module usa_alias import usa_pkg::*; #(
  parameter int RX_DEPTH = USA_FIFO_DEPTH,
  parameter int TX_DEPTH = USA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Received characters from the deserialisers
  input wire logic sin_valid,
  input wire logic [7:0] sin_byte,
  input wire logic sir_valid,
  input wire logic [7:0] sir_byte,
  // Characters to the serialiser
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic ir_mode,
  // Interrupt
  output logic irq
);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);

  logic aw_q, w_q, bvalid_q, ovr_q, txe_prev_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  usa_rd_state_t rd_st_q;
  logic [7:0] fc_q;
  logic [USA_INT_NUM-1:0] ist_q, ien_q;

  logic fifo_en, wr_do, lane0, wr_alias, wr_fc, wr_ok, ar_fire, rd_pop, ls_rd;
  logic rx_in_v, rx_flush, tx_flush, rx_empty, rx_full, tx_empty, tx_full, tx_pop;
  logic overrun_ev, tx_drop_ev;
  logic [7:0] rx_in_b, rx_head, ls_val;
  logic [RCW-1:0] rx_count;
  logic [TCW-1:0] tx_count;
  logic [USA_INT_NUM-1:0] ev;
  logic [31:0] rd_d;
  logic [1:0] rresp_d;

  function automatic logic is_alias(input logic [31:0] a);
    return (a >= USA_ALIAS_BASE) && (a <= USA_ALIAS_LAST) && (a[1:0] == 2'h0);
  endfunction

  assign fifo_en = fc_q[USA_FC_FIFO_EN];
  assign ir_mode = fc_q[USA_FC_IR_MODE];

  // Write channel: address and data taken independently
  assign awready = !aw_q;
  assign wready = !w_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign wr_do = aw_q && w_q && !bvalid_q;
  assign lane0 = wstrb_q[0];
  assign wr_alias = wr_do && lane0 && is_alias(awaddr_q); // R1 R13
  assign wr_fc = wr_do && lane0 && (awaddr_q == USA_FIFO_CONTROL_ADDR);
  assign wr_ok = is_alias(awaddr_q) || (awaddr_q == USA_LINE_STATUS_ADDR)
    || (awaddr_q == USA_FIFO_CONTROL_ADDR) || (awaddr_q == USA_FIFO_LEVEL_ADDR)
    || (awaddr_q == USA_INT_STATUS_ADDR) || (awaddr_q == USA_INT_ENABLE_ADDR)
    || (awaddr_q == USA_INT_CLEAR_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_do) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_do) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= USA_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? USA_RESP_OKAY : USA_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // FIFO mode and infrared select; reset strobes are masked off and not held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_q <= USA_FC_RESET;
    end else if (wr_fc) begin
      fc_q <= wdata_q[7:0] & 8'h11;
    end
  end

  // Toggling FIFO mode empties both queues; each reset strobe empties its own queue
  assign rx_flush = wr_fc && (wdata_q[USA_FC_RX_RESET]
    || (wdata_q[USA_FC_FIFO_EN] != fifo_en));
  assign tx_flush = wr_fc && (wdata_q[USA_FC_TX_RESET]
    || (wdata_q[USA_FC_FIFO_EN] != fifo_en));

  // Receive path
  assign rx_in_v = ir_mode ? sir_valid : sin_valid; // R2
  assign rx_in_b = ir_mode ? sir_byte : sin_byte; // R2
  assign ar_fire = arvalid && arready;
  // Pop only when a byte is held, so an early read costs nothing
  assign rd_pop = ar_fire && is_alias(araddr) && !rx_empty; // R3 R13
  assign ls_rd = ar_fire && (araddr == USA_LINE_STATUS_ADDR);

  usa_fifo #(
    .W(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .flush(rx_flush),
    .one_deep(!fifo_en), // R4 R5
    .push(rx_in_v),
    .din(rx_in_b),
    .pop(rd_pop),
    .head(rx_head),
    .empty(rx_empty),
    .full(rx_full),
    .count(rx_count)
  );

  // Single mode overwrites, FIFO mode drops; both flag overrun
  assign overrun_ev = rx_in_v && rx_full && !rd_pop && !rx_flush; // R4 R6

  // Overrun clears on line_status read; a new overrun wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= 1'b0;
    end else if (overrun_ev) begin
      ovr_q <= 1'b1; // R4 R6
    end else if (ls_rd) begin
      ovr_q <= 1'b0;
    end
  end

  // Transmit path
  assign tx_valid = !tx_empty; // R7
  assign tx_pop = tx_valid && tx_ready;

  usa_fifo #(
    .W(8),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .flush(tx_flush),
    .one_deep(!fifo_en), // R9 R10
    .push(wr_alias), // R7 R11
    .din(wdata_q[7:0]),
    .pop(tx_pop),
    .head(tx_byte),
    .empty(tx_empty),
    .full(tx_full),
    .count(tx_count)
  );

  assign tx_drop_ev = wr_alias && fifo_en && tx_full && !tx_pop; // R12

  // Holding empty is the transmit queue being empty
  assign ls_val = {2'h0, tx_empty, 3'h0, ovr_q, !rx_empty}; // R3 R9

  // Interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txe_prev_q <= 1'b1;
    end else begin
      txe_prev_q <= tx_empty;
    end
  end

  always_comb begin
    ev = '0;
    ev[USA_IS_RX_DATA] = rx_in_v && !overrun_ev;
    ev[USA_IS_OVERRUN] = overrun_ev;
    ev[USA_IS_TX_EMPTY] = tx_empty && !txe_prev_q;
    ev[USA_IS_TX_DROP] = tx_drop_ev;
  end

  // Sticky bits: a set in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= USA_INT_RESET;
    end else if (wr_do && lane0 && (awaddr_q == USA_INT_CLEAR_ADDR)) begin
      ist_q <= (ist_q & ~wdata_q[USA_INT_NUM-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_q <= USA_INT_RESET;
    end else if (wr_do && lane0 && (awaddr_q == USA_INT_ENABLE_ADDR)) begin
      ien_q <= wdata_q[USA_INT_NUM-1:0];
    end
  end

  assign irq = |(ist_q & ien_q);

  // Read channel
  always_comb begin
    rd_d = '0;
    rresp_d = USA_RESP_OKAY;
    if (is_alias(araddr)) begin
      rd_d[7:0] = rx_head; // R2 R5 R13
    end else if (araddr == USA_LINE_STATUS_ADDR) begin
      rd_d[7:0] = ls_val;
    end else if (araddr == USA_FIFO_CONTROL_ADDR) begin
      rd_d[7:0] = fc_q;
    end else if (araddr == USA_FIFO_LEVEL_ADDR) begin
      rd_d[RCW-1:0] = rx_count;
      rd_d[USA_LVL_TX_LSB +: TCW] = tx_count;
    end else if (araddr == USA_INT_STATUS_ADDR) begin
      rd_d[USA_INT_NUM-1:0] = ist_q;
    end else if (araddr == USA_INT_ENABLE_ADDR) begin
      rd_d[USA_INT_NUM-1:0] = ien_q;
    end else if (araddr == USA_INT_CLEAR_ADDR) begin
      rd_d = '0;
    end else begin
      rresp_d = USA_RESP_SLVERR;
    end
  end

  assign arready = (rd_st_q == USA_RD_IDLE);
  assign rvalid = (rd_st_q == USA_RD_RESP);
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_q <= USA_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= USA_RESP_OKAY;
    end else begin
      case (rd_st_q)
        USA_RD_IDLE: begin
          if (arvalid) begin
            rd_st_q <= USA_RD_RESP;
            rdata_q <= rd_d;
            rresp_q <= rresp_d;
          end
        end
        USA_RD_RESP: begin
          if (rready) begin
            rd_st_q <= USA_RD_IDLE;
          end
        end
        default: begin
          rd_st_q <= USA_RD_IDLE;
        end
      endcase
    end
  end

  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Level register uses bits above 7, so only alias reads are held to zero
  rd_upper_zero_a: assert property ( // R2
    ar_fire && is_alias(araddr) |=> rvalid && rdata[31:8] == 24'h0)
    else $error("alias read upper bits not zero");
  rd_empty_hold_a: assert property ( // R3
    ar_fire && is_alias(araddr) && rx_empty && !rx_in_v |=> rx_empty)
    else $error("empty alias read changed receive state");
  single_ovw_a: assert property ( // R4
    !fifo_en && rx_in_v && !rx_empty && !rd_pop && !rx_flush
    |=> rx_head == $past(rx_in_b) && ovr_q && rx_count == RCW'(1))
    else $error("single mode overwrite or overrun missing");
  rd_head_a: assert property ( // R5
    rd_pop |=> rvalid && rdata == {24'h0, $past(rx_head)})
    else $error("alias read did not return queue head");
  full_drop_a: assert property ( // R6
    fifo_en && rx_full && rx_in_v && !rd_pop && !rx_flush
    |=> rx_full && rx_head == $past(rx_head) && ovr_q)
    else $error("full receive queue not preserved");
  tx_hold_a: assert property ( // R7
    fifo_en && tx_valid && !tx_ready && !tx_flush |=> tx_valid && $stable(tx_byte))
    else $error("pending transmit byte lost");
  txe_clear_a: assert property ( // R9
    !fifo_en && wr_alias && tx_empty && !tx_flush |=> !ls_val[USA_LS_TX_EMPTY])
    else $error("write did not clear holding empty");
  tx_ovw_a: assert property ( // R10
    !fifo_en && wr_alias && !tx_empty && !tx_pop && !tx_flush
    |=> tx_byte == $past(wdata_q[7:0]) && tx_count == TCW'(1))
    else $error("single mode write did not overwrite");
  tx_accept_a: assert property ( // R11
    fifo_en && wr_alias && !tx_full && !tx_pop && !tx_flush
    |=> tx_count == $past(tx_count) + TCW'(1))
    else $error("transmit queue refused a write");
  tx_drop_a: assert property ( // R12
    tx_drop_ev && !tx_flush |=> tx_full && $stable(tx_byte))
    else $error("write into full transmit queue stored");
  pop_once_a: assert property ( // R13
    rd_pop && !rx_in_v && !rx_flush |=> rx_count == $past(rx_count) - RCW'(1))
    else $error("alias read did not pop exactly once");

  overrun_cov: cover property (overrun_ev && fifo_en);
  tx_drop_cov: cover property (tx_drop_ev);
  irq_cov: cover property (!irq ##1 irq);
  pop_cov: cover property (rd_pop ##2 rd_pop);
endmodule
`default_nettype wire

/* File: src/usa_fifo.sv */
// Character queue with flush, single-entry overwrite mode and drop when full
`timescale 1ns/100ps
`default_nettype none
module usa_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  input wire logic one_deep,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] din,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] head,
  // Level
  output logic empty,
  output logic full,
  output logic [CW-1:0] count
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [CW-1:0] cnt_q;
  logic do_pop;
  logic do_push;
  logic do_ovw;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign empty = (cnt_q == '0);
  // Single-entry mode looks full once one character is held
  assign full = one_deep ? !empty : (cnt_q == CW'(DEPTH));
  assign count = cnt_q;
  assign head = mem_q[rd_q];
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign do_ovw = push && full && !do_pop && one_deep;

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      cnt_q <= '0;
      rd_q <= '0;
      wr_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= nxt(wr_q);
      end
      if (do_pop) begin
        rd_q <= nxt(rd_q);
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage carries no reset; only the pointers matter
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_q] <= din;
    end else if (do_ovw) begin
      mem_q[rd_q] <= din;
    end
  end
endmodule
`default_nettype wire

/* File: src/usa_pkg.sv */
// Package: addresses, field positions and reset values of the UART shadow alias block
package usa_pkg;
  // Shadow alias window: sixteen aligned words
  localparam logic [31:0] USA_ALIAS_BASE = 32'h5000_1130;
  localparam logic [31:0] USA_ALIAS_LAST = 32'h5000_116c;
  localparam logic [31:0] USA_SHADOW_RX_TX_ALIAS_2 = 32'h5000_1138;
  localparam logic [31:0] USA_SHADOW_RX_TX_ALIAS_3 = 32'h5000_113c;
  // Control, status and interrupt registers
  localparam logic [31:0] USA_LINE_STATUS_ADDR = 32'h5000_1180;
  localparam logic [31:0] USA_FIFO_CONTROL_ADDR = 32'h5000_1184;
  localparam logic [31:0] USA_FIFO_LEVEL_ADDR = 32'h5000_1188;
  localparam logic [31:0] USA_INT_STATUS_ADDR = 32'h5000_118c;
  localparam logic [31:0] USA_INT_ENABLE_ADDR = 32'h5000_1190;
  localparam logic [31:0] USA_INT_CLEAR_ADDR = 32'h5000_1194;
  // line_status fields
  localparam int USA_LS_DATA_READY = 0;
  localparam int USA_LS_OVERRUN = 1;
  localparam int USA_LS_TX_EMPTY = 5;
  // fifo_control fields
  localparam int USA_FC_FIFO_EN = 0;
  localparam int USA_FC_RX_RESET = 1;
  localparam int USA_FC_TX_RESET = 2;
  localparam int USA_FC_IR_MODE = 4;
  // fifo level fields
  localparam int USA_LVL_TX_LSB = 8;
  // Interrupt status fields
  localparam int USA_IS_RX_DATA = 0;
  localparam int USA_IS_OVERRUN = 1;
  localparam int USA_IS_TX_EMPTY = 2;
  localparam int USA_IS_TX_DROP = 3;
  localparam int USA_INT_NUM = 4;
  // Reset values
  localparam logic [7:0] USA_FC_RESET = 8'h00;
  localparam logic [3:0] USA_INT_RESET = 4'h0;
  localparam int USA_FIFO_DEPTH = 16;
  // AXI responses
  localparam logic [1:0] USA_RESP_OKAY = 2'h0;
  localparam logic [1:0] USA_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    USA_RD_IDLE = 2'h1,
    USA_RD_RESP = 2'h2
  } usa_rd_state_t;
endpackage

/* File: verification/tb_top.sv */
// Self-checking bench for the shadow alias block
`timescale 1ns/100ps
`default_nettype none
module tb_top import usa_pkg::*;;
  localparam int DEP = 4;
  localparam logic [1:0] OK = USA_RESP_OKAY;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, ir_mode, irq;
  logic sin_valid, sir_valid;
  logic [1:0] bresp, rresp;
  logic [7:0] tx_byte, sin_byte, sir_byte, b;
  int err_count, n_checks, cyc;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [7:0] exp_tx[$], q[$];

  usa_alias #(.RX_DEPTH(DEP), .TX_DEPTH(DEP)) i_dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .sin_valid, .sin_byte, .sir_valid, .sir_byte,
    .tx_valid, .tx_byte, .tx_ready, .ir_mode, .irq);
  usa_line_model i_line (.aclk, .aresetn, .ir_mode, .sin_valid, .sin_byte, .sir_valid,
    .sir_byte, .stall, .tx_ready);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic wrap_up;
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [33:0] ok(input logic [31:0] d);
    return {OK, d};
  endfunction

  function automatic logic [33:0] ls(input logic t, input logic o, input logic d);
    return ok(32'(t) << USA_LS_TX_EMPTY | 32'(o) << USA_LS_OVERRUN | 32'(d));
  endfunction

  // Any of the sixteen aliases must behave the same
  function automatic logic [31:0] alias_addr();
    return USA_ALIAS_BASE + 32'($urandom_range(0, 15)) * 32'h4;
  endfunction

  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    // Ready stays high after the answer; each call drives it high again with the request
    while (!bvalid) @(posedge aclk);
  endtask

  task automatic axr(input logic [31:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask

  task automatic drain;
    stall <= 1'b0;
    while (exp_tx.size() != 0) @(posedge aclk);
    stall <= 1'b1;
  endtask

  task automatic irq_is(input logic v);
    @(posedge aclk);
    chk(34'(irq), 34'(v));
  endtask

  // Scoreboard: oldest note against each result as it appears
  always @(posedge aclk) begin
    if (aresetn && rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
    if (aresetn && bvalid && bready) chk(34'(bresp), 34'(exp_b.pop_front()));
    if (aresetn && tx_valid && tx_ready) chk(34'(tx_byte), 34'(exp_tx.pop_front()));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    stall = 1'b1;
    void'($urandom(58310));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(USA_LINE_STATUS_ADDR, ls(1, 0, 0));
    axr(USA_FIFO_CONTROL_ADDR, ok(32'(USA_FC_RESET)));
    axr(USA_INT_STATUS_ADDR, ok(32'(USA_INT_RESET)));
    axw(32'h5000_11a0, 32'h0, USA_RESP_SLVERR);
    axr(32'h5000_11a0, {USA_RESP_SLVERR, 32'h0});
    axw(USA_INT_ENABLE_ADDR, 32'hf, OK);
    // Single-entry mode: unread byte is overwritten
    b = 8'($urandom);
    i_line.send(~b, 1'b0);
    i_line.send(b, 1'b0);
    irq_is(1'b1);
    axr(USA_LINE_STATUS_ADDR, ls(1, 1, 1));
    axr(USA_SHADOW_RX_TX_ALIAS_2, ok(32'(b)));
    axr(USA_LINE_STATUS_ADDR, ls(1, 0, 0));
    axw(USA_INT_ENABLE_ADDR, 32'h0, OK);
    irq_is(1'b0);
    axw(USA_INT_CLEAR_ADDR, 32'hf, OK);
    axw(USA_INT_ENABLE_ADDR, 32'hf, OK);
    irq_is(1'b0);
    // Second write before the line drains replaces the first
    axw(USA_SHADOW_RX_TX_ALIAS_3, {24'($urandom), ~b}, OK);
    axw(USA_SHADOW_RX_TX_ALIAS_3, {24'($urandom), b}, OK);
    axr(USA_LINE_STATUS_ADDR, ls(0, 0, 0));
    exp_tx.push_back(b);
    drain();
    axr(USA_LINE_STATUS_ADDR, ls(1, 0, 0));
    irq_is(1'b1);
    axw(USA_INT_CLEAR_ADDR, 32'hf, OK);
    // Queue mode: fill transmit queue past its depth while stalled
    axw(USA_FIFO_CONTROL_ADDR, 32'h1, OK);
    for (int i = 0; i <= DEP; i++) begin
      b = 8'($urandom);
      if (i < DEP) exp_tx.push_back(b);
      axw(alias_addr(), {24'h0, b}, OK);
    end
    axr(USA_INT_STATUS_ADDR, ok(32'(1) << USA_IS_TX_DROP));
    axr(USA_FIFO_LEVEL_ADDR, ok(32'(DEP) << USA_LVL_TX_LSB));
    drain();
    // Receive queue overflows; head order kept, extra byte lost
    for (int i = 0; i <= DEP; i++) begin
      b = 8'($urandom);
      q.push_back(b);
      i_line.send(b, 1'b0);
    end
    axr(USA_LINE_STATUS_ADDR, ls(1, 1, 1));
    for (int i = 0; i < DEP; i++) axr(alias_addr(), ok(32'(q[i])));
    axr(USA_LINE_STATUS_ADDR, ls(1, 0, 0));
    // Infrared mode: only the infrared line is heard
    axw(USA_FIFO_CONTROL_ADDR, 32'h11, OK);
    @(posedge aclk);
    chk(34'(ir_mode), 34'h1);
    b = 8'($urandom);
    i_line.send(b, 1'b1);
    axr(alias_addr(), ok(32'(b)));
    // Empty read shows stale storage of the next slot and must not pop
    axr(alias_addr(), ok(32'(q[1])));
    axr(USA_LINE_STATUS_ADDR, ls(1, 0, 0));
    exp_tx.push_back(~b);
    axw(alias_addr(), {24'h0, ~b}, OK);
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: verification/usa_line_model.sv */
// Far-side model: deserialisers feeding characters in, serialiser taking them out
`timescale 1ns/100ps
`default_nettype none
module usa_line_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Receive side
  input wire logic ir_mode,
  output logic sin_valid,
  output logic [7:0] sin_byte,
  output logic sir_valid,
  output logic [7:0] sir_byte,
  // Transmit side
  input wire logic stall,
  output logic tx_ready
);
  initial begin
    sin_valid = 1'b0;
    sir_valid = 1'b0;
    sin_byte = 8'h00;
    sir_byte = 8'hff;
  end

  // Accepts promptly or slowly; never from the cycle after the bench stalls it
  always_ff @(posedge aclk) begin
    if (!aresetn || stall) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ($urandom_range(0, 3) != 0);
    end
  end

  // Wrong marks a junk character on the line that is not selected
  task automatic send(input logic [7:0] b, input logic wrong);
    sin_valid <= !ir_mode || wrong;
    sin_byte <= ir_mode ? ~b : b;
    sir_valid <= ir_mode || wrong;
    sir_byte <= ir_mode ? b : ~b;
    @(posedge aclk);
    sin_valid <= 1'b0;
    sir_valid <= 1'b0;
    // Stale bytes are inverted so nothing can match by accident
    sin_byte <= ~sin_byte;
    sir_byte <= ~sir_byte;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire
